// File: core/spm_pkg.sv
// package of constants, types and state for the serial port modem pin block
package spm_pkg;

    // number of serial ports
    localparam int SPM_PORTS = 2;

    // bit of the extended control register that selects baud output
    localparam int SPM_EXT_BAUD_OUT_BIT = 7;

    // configuration index/data base addresses chosen by the address strap
    localparam logic [7:0] SPM_CFG_BASE_LO = 8'h2E;
    localparam logic [7:0] SPM_CFG_BASE_HI = 8'h4E;

    // reset level of modem-control outputs and serial out (inactive high)
    localparam logic SPM_MCTL_RESET = 1'b1;
    localparam logic SPM_SOUT_RESET = 1'b1;

    // release count after reset; strap pins stay released this many cycles plus two after reset leaves
    localparam int SPM_STRAP_SETTLE = 2;

    // fifo defaults
    localparam int SPM_FIFO_DEPTH = 32;
    localparam int SPM_DATA_W     = 8;

    // strap sampling sequence
    typedef enum logic [1:0] {
        SPM_ST_RELEASE = 2'b00,
        SPM_ST_SAMPLE  = 2'b01,
        SPM_ST_RUN     = 2'b10
    } spm_strap_e;

    // uart-side modem controls for one port
    typedef struct packed {
        logic dtr_on;   // uart ready for link (active high internally)
        logic rts_on;   // uart ready to exchange data
        logic loop;     // loopback operation
        logic baud_clk; // baud rate generator output
        logic sout;     // serial data from transmitter
        logic tx_busy;  // transmission has begun
    } spm_ctl_s;

    // synchronised, decoded modem status for one port (active high)
    typedef struct packed {
        logic cts;
        logic dsr;
        logic dcd;
        logic ring;
        logic sin;
    } spm_stat_s;

    // straps caught in the sample step, after the release count runs out
    typedef struct packed {
        logic [7:0] cfg_base;
        logic       test_mode;
    } spm_strap_s;

endpackage

// File: core/spm_sync2.sv
// two flip-flop synchroniser, one per bit
`timescale 1ns/1ps
`default_nettype none
module spm_sync2 #(
    parameter int W = 5
) (
    input  wire logic         ref_clk_i,
    input  wire logic         rst_b_i,
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] sync_o
);
    // refuse an empty synchroniser
    if (W < 1)
    begin : g_bad_w
        $error("spm_sync2 needs at least one bit");
    end

    // both stages of the synchroniser
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } spm_sync_s;

    spm_sync_s state_r;   // registered stages
    spm_sync_s state_nxt; // next stages

    // first stage feeds only the second
    always_comb
    begin
        state_nxt.s1 = async_i;
        state_nxt.s2 = state_r.s1;
    end

    // reset to all ones: idle-high pins
    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            state_r <= '1;
        end
        else
        begin
            state_r <= state_nxt;
        end
    end

    assign sync_o = state_r.s2;
endmodule // spm_sync2
`default_nettype wire

// File: core/spm_fifo.sv
// parameterised synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module spm_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    input  wire logic             ref_clk_i,
    input  wire logic             rst_b_i,
    input  wire logic [WIDTH-1:0] in_data_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    output logic      [WIDTH-1:0] out_data_o,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i
);
    localparam int AW = $clog2(DEPTH);

    // refuse depths that the pointers cannot serve
    if (DEPTH < 2 || (1 << AW) != DEPTH)
    begin : g_bad_depth
        $error("spm_fifo depth must be a power of two of at least 2");
    end

    // pointers carry one wrap bit
    typedef struct packed {
        logic [AW:0]      wr;
        logic [AW:0]      rd;
        logic [WIDTH-1:0] dout;
        logic             dval;
    } spm_fifo_s;

    spm_fifo_s        state_r;   // registered pointers and output stage
    spm_fifo_s        state_nxt; // next value
    logic [WIDTH-1:0] mem_r [DEPTH]; // storage
    logic             full;      // every slot used
    logic             empty;     // no word stored
    logic             push;      // word accepted
    logic             pop;       // word moved to output stage

    assign full       = (state_r.wr[AW] != state_r.rd[AW]) &&
                        (state_r.wr[AW-1:0] == state_r.rd[AW-1:0]);
    assign empty      = (state_r.wr == state_r.rd);
    assign in_ready_o = !full;
    assign push       = in_valid_i && !full;
    assign pop        = !empty && (!state_r.dval || out_ready_i);

    // pointer and output stage update
    always_comb
    begin
        state_nxt = state_r;
        if (push)
        begin
            state_nxt.wr = state_r.wr + 1'b1;
        end
        if (pop)
        begin
            state_nxt.rd   = state_r.rd + 1'b1;
            state_nxt.dout = mem_r[state_r.rd[AW-1:0]];
            state_nxt.dval = 1'b1;
        end
        else if (out_ready_i)
        begin
            state_nxt.dval = 1'b0;
        end
    end

    // control state with reset
    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            state_r <= '0;
        end
        else
        begin
            state_r <= state_nxt;
        end
    end

    // storage, no reset needed
    always_ff @(posedge ref_clk_i)
    begin
        if (push)
        begin
            mem_r[state_r.wr[AW-1:0]] <= in_data_i;
        end
    end

    assign out_data_o  = state_r.dout;
    assign out_valid_o = state_r.dval;
endmodule // spm_fifo
`default_nettype wire

// File: core/spm_pins.sv
// pin stage of two serial ports: modem controls, status, straps, fifo
`timescale 1ns/1ps
`default_nettype none
module spm_pins
    import spm_pkg::*;
#(
    parameter int PORTS      = SPM_PORTS,
    parameter int FIFO_DEPTH = SPM_FIFO_DEPTH,
    parameter int DATA_W     = SPM_DATA_W
) (
    input  wire logic              ref_clk_i,
    input  wire logic              rst_b_i,
    // uart core side, per port
    input  wire logic [PORTS-1:0]  dtr_on_i,       // uart ready for link
    input  wire logic [PORTS-1:0]  rts_on_i,       // uart ready to exchange
    input  wire logic [PORTS-1:0]  loop_i,         // loopback operation
    input  wire logic [PORTS-1:0]  baud_clk_i,     // baud generator output
    input  wire logic [PORTS-1:0]  sout_i,         // transmitter data bit
    input  wire logic [PORTS-1:0]  tx_busy_i,      // transmission started
    input  wire logic [PORTS-1:0]  extended_control_one_bit7_i, // baud out select
    output logic      [PORTS-1:0]  cts_o,          // far end ready, high true
    output logic      [PORTS-1:0]  dsr_o,          // far end link ready
    output logic      [PORTS-1:0]  dcd_o,          // carrier detected
    output logic      [PORTS-1:0]  ring_o,         // ring seen
    output logic      [PORTS-1:0]  sin_o,          // synchronised serial in
    output logic                   ring_wake_o,    // any ring, wake event
    // received-bit stream through the fifo, port 1
    input  wire logic              rx_valid_i,
    input  wire logic [DATA_W-1:0] rx_data_i,
    output logic                   rx_ready_o,
    output logic                   rx_valid_o,
    output logic      [DATA_W-1:0] rx_data_o,
    input  wire logic              rx_ready_i,
    // straps
    output logic      [7:0]        cfg_base_o,     // index port address
    output logic                   test_mode_o,    // test mode entered
    output logic                   strap_done_o,   // straps have been sampled
    // pins
    input  wire logic [PORTS-1:0]  cts_b_i,
    input  wire logic [PORTS-1:0]  dsr_b_i,
    input  wire logic [PORTS-1:0]  dcd_b_i,
    input  wire logic [PORTS-1:0]  ri_b_i,
    input  wire logic [PORTS-1:0]  sin_i,
    output logic      [PORTS-1:0]  sout_o,
    output logic      [PORTS-1:0]  rts_b_o,
    output logic      [PORTS-1:0]  rts_b_oe_o,
    input  wire logic              port1_rts_pin_i, // test strap read-back
    output logic      [PORTS-1:0]  port_terminal_ready_or_baud_pin_o,
    output logic      [PORTS-1:0]  port_terminal_ready_or_baud_pin_oe_o,
    input  wire logic              port1_terminal_ready_or_baud_pin_i // address strap
);
    localparam int SW = 5; // synchronised bits per port

    // refuse configurations the strap logic cannot serve
    if (PORTS < 1)
    begin : g_bad_ports
        $error("spm_pins needs at least one port");
    end

    // whole module state
    typedef struct packed {
        spm_strap_e             phase;    // strap sequence
        logic [1:0]             settle;   // release cycles left
        spm_strap_s             strap;    // caught straps
        logic [PORTS-1:0]       dtr_b;    // registered dtr/baud pin level
        logic [PORTS-1:0]       rts_b;    // registered rts pin level
        logic [PORTS-1:0]       sout;     // registered serial out
        logic [PORTS-1:0]       cts;      // decoded status
        logic [PORTS-1:0]       dsr;
        logic [PORTS-1:0]       dcd;
        logic [PORTS-1:0]       ring;
        logic [PORTS-1:0]       sin;
        logic                   wake;     // any ring
    } spm_state_s;

    spm_state_s             state_r;   // registered state
    spm_state_s             state_nxt; // next state
    logic [PORTS*SW-1:0]    raw;       // pins into synchroniser
    logic [PORTS*SW-1:0]    synced;    // synchroniser outputs

    // gather status pins and serial in for every port
    for (genvar p = 0; p < PORTS; p++)
    begin : g_gather
        assign raw[p*SW +: SW] = {cts_b_i[p], dsr_b_i[p], dcd_b_i[p], ri_b_i[p], sin_i[p]};
    end

    // every status input crosses two flops before use
    spm_sync2 #(
        .W (PORTS*SW)
    ) u_sync (
        .ref_clk_i   (ref_clk_i),
        .rst_b_i     (rst_b_i),
        .async_i     (raw),
        .sync_o      (synced)
    );

    // received stream buffer
    spm_fifo #(
        .WIDTH (DATA_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .ref_clk_i   (ref_clk_i),
        .rst_b_i     (rst_b_i),
        .in_data_i   (rx_data_i),
        .in_valid_i  (rx_valid_i),
        .in_ready_o  (rx_ready_o),
        .out_data_o  (rx_data_o),
        .out_valid_o (rx_valid_o),
        .out_ready_i (rx_ready_i)
    );

    // next-state logic
    always_comb
    begin
        state_nxt = state_r;
        // strap sequence: pins released, then sampled once, then driven
        unique case (state_r.phase)
            SPM_ST_RELEASE:
            begin
                // wait for the external straps to settle
                if (state_r.settle == 2'h0)
                begin
                    state_nxt.phase = SPM_ST_SAMPLE;
                end
                else
                begin
                    state_nxt.settle = state_r.settle - 2'h1;
                end
            end
            SPM_ST_SAMPLE:
            begin
                // address strap on port 1 dtr pin
                state_nxt.strap.cfg_base = port1_terminal_ready_or_baud_pin_i ?
                                           SPM_CFG_BASE_HI : SPM_CFG_BASE_LO;
                // test strap on port 1 rts pin
                state_nxt.strap.test_mode = port1_rts_pin_i;
                state_nxt.phase           = SPM_ST_RUN;
            end
            SPM_ST_RUN:
            begin
                state_nxt.phase = SPM_ST_RUN;
            end
            default:
            begin
                state_nxt.phase = SPM_ST_RELEASE;
            end
        endcase
        // per-port pin drive and status decode
        for (int p = 0; p < PORTS; p++)
        begin
            if (state_r.phase != SPM_ST_RUN)
            begin
                // reset levels: dtr function, inactive high
                state_nxt.dtr_b[p] = SPM_MCTL_RESET;
                state_nxt.rts_b[p] = SPM_MCTL_RESET;
                state_nxt.sout[p]  = SPM_SOUT_RESET;
            end
            else
            begin
                if (extended_control_one_bit7_i[p])
                begin
                    // baud generator clock replaces dtr
                    state_nxt.dtr_b[p] = baud_clk_i[p];
                end
                else if (loop_i[p])
                begin
                    // loopback forces inactive
                    state_nxt.dtr_b[p] = SPM_MCTL_RESET;
                end
                else
                begin
                    // low only when uart ready for link
                    state_nxt.dtr_b[p] = !dtr_on_i[p];
                end
                // loopback forces rts inactive
                state_nxt.rts_b[p] = loop_i[p] ? SPM_MCTL_RESET : !rts_on_i[p];
                // serial out idles high until transmission starts
                state_nxt.sout[p] = (tx_busy_i[p] && !loop_i[p]) ?
                                    sout_i[p] : SPM_SOUT_RESET;
            end
            // active-low status decoded to high-true
            state_nxt.cts[p]  = !synced[p*SW+4];
            state_nxt.dsr[p]  = !synced[p*SW+3];
            state_nxt.dcd[p]  = !synced[p*SW+2];
            state_nxt.ring[p] = !synced[p*SW+1];
            state_nxt.sin[p]  = synced[p*SW];
        end
        // ring watched regardless of port state, as a wake event
        state_nxt.wake = |state_nxt.ring;
    end

    // state register
    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            state_r                 <= '0;
            state_r.phase           <= SPM_ST_RELEASE;
            state_r.settle          <= 2'(SPM_STRAP_SETTLE);
            state_r.strap.cfg_base  <= SPM_CFG_BASE_LO;
            state_r.dtr_b           <= '1;
            state_r.rts_b           <= '1;
            state_r.sout            <= '1;
            state_r.sin             <= '1;
        end
        else
        begin
            state_r <= state_nxt;
        end
    end

    // strap pins stay released until sampling is over
    always_comb
    begin
        port_terminal_ready_or_baud_pin_oe_o = '1;
        rts_b_oe_o                           = '1;
        if (state_r.phase != SPM_ST_RUN)
        begin
            port_terminal_ready_or_baud_pin_oe_o[0] = 1'b0;
            rts_b_oe_o[0]                           = 1'b0;
        end
    end

    assign port_terminal_ready_or_baud_pin_o = state_r.dtr_b;
    assign rts_b_o      = state_r.rts_b;
    assign sout_o       = state_r.sout;
    assign cts_o        = state_r.cts;
    assign dsr_o        = state_r.dsr;
    assign dcd_o        = state_r.dcd;
    assign ring_o       = state_r.ring;
    assign sin_o        = state_r.sin;
    assign ring_wake_o  = state_r.wake;
    assign cfg_base_o   = state_r.strap.cfg_base;
    assign test_mode_o  = state_r.strap.test_mode;
    assign strap_done_o = (state_r.phase == SPM_ST_RUN);
endmodule // spm_pins
`default_nettype wire

// File: tb/spm_pins_chk.sv
// concurrent checks on the pin stage ports, bound to spm_pins
`timescale 1ns/1ps
`default_nettype none
module spm_pins_chk
    import spm_pkg::*;
#(
    parameter int PORTS  = SPM_PORTS,
    parameter int DATA_W = SPM_DATA_W
) (
    input wire logic              ref_clk_i,
    input wire logic              rst_b_i,
    input wire logic [PORTS-1:0]  dtr_on_i,
    input wire logic [PORTS-1:0]  rts_on_i,
    input wire logic [PORTS-1:0]  loop_i,
    input wire logic [PORTS-1:0]  baud_clk_i,
    input wire logic [PORTS-1:0]  sout_i,
    input wire logic [PORTS-1:0]  tx_busy_i,
    input wire logic [PORTS-1:0]  extended_control_one_bit7_i,
    input wire logic [PORTS-1:0]  cts_o,
    input wire logic [PORTS-1:0]  dsr_o,
    input wire logic [PORTS-1:0]  dcd_o,
    input wire logic [PORTS-1:0]  ring_o,
    input wire logic              rx_valid_o,
    input wire logic [DATA_W-1:0] rx_data_o,
    input wire logic              rx_ready_i,
    input wire logic [7:0]        cfg_base_o,
    input wire logic              test_mode_o,
    input wire logic              strap_done_o,
    input wire logic [PORTS-1:0]  cts_b_i,
    input wire logic [PORTS-1:0]  dsr_b_i,
    input wire logic [PORTS-1:0]  dcd_b_i,
    input wire logic [PORTS-1:0]  ri_b_i,
    input wire logic [PORTS-1:0]  sout_o,
    input wire logic [PORTS-1:0]  rts_b_o,
    input wire logic [PORTS-1:0]  rts_b_oe_o,
    input wire logic              port1_rts_pin_i,
    input wire logic [PORTS-1:0]  port_terminal_ready_or_baud_pin_o,
    input wire logic [PORTS-1:0]  port_terminal_ready_or_baud_pin_oe_o,
    input wire logic              port1_terminal_ready_or_baud_pin_i
);
    // one clock domain, asynchronous low reset
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!rst_b_i);

    // pins follow uart controls one cycle later once straps are taken
    dtr_pin_a: assert property (
        $past(strap_done_o) |-> port_terminal_ready_or_baud_pin_o ==
        (($past(extended_control_one_bit7_i) & $past(baud_clk_i)) |
        (~$past(extended_control_one_bit7_i) & ($past(loop_i) | ~$past(dtr_on_i)))))
        else $error("dtr pin wrong");
    rts_pin_a: assert property (
        $past(strap_done_o) |-> rts_b_o == ($past(loop_i) | ~$past(rts_on_i)))
        else $error("rts pin wrong");
    sout_idle_a: assert property (
        $past(strap_done_o) |-> sout_o == (~($past(tx_busy_i) & ~$past(loop_i)) | $past(sout_i)))
        else $error("serial out wrong");
    // strap pins stay released until sampled
    strap_hold_a: assert property (
        !strap_done_o |-> !port_terminal_ready_or_baud_pin_oe_o[0] && !rts_b_oe_o[0] &&
        rts_b_o[0])
        else $error("strap pin driven early");
    base_strap_a: assert property (
        $rose(strap_done_o) |-> cfg_base_o ==
        ($past(port1_terminal_ready_or_baud_pin_i) ? 8'h4E : 8'h2E))
        else $error("base address strap wrong");
    test_strap_a: assert property (
        $rose(strap_done_o) |-> test_mode_o == $past(port1_rts_pin_i))
        else $error("test strap wrong");
    // two sync flops plus decode: three cycles, low pin reads as true
    status_dec_a: assert property (
        strap_done_o |-> {ring_o, dcd_o, dsr_o, cts_o} ==
        ~{$past(ri_b_i, 3), $past(dcd_b_i, 3), $past(dsr_b_i, 3), $past(cts_b_i, 3)})
        else $error("modem status decode wrong");
    // a stalled output word holds
    fifo_hold_a: assert property (
        rx_valid_o && !rx_ready_i |=> rx_valid_o && $stable(rx_data_o))
        else $error("fifo output dropped while stalled");

    // main scenarios reached
    cover property (strap_done_o && |extended_control_one_bit7_i);
    cover property ($rose(strap_done_o) && test_mode_o);
    cover property (rx_valid_o && !rx_ready_i);
endmodule // spm_pins_chk

bind spm_pins spm_pins_chk #(.PORTS(PORTS), .DATA_W(DATA_W)) u_chk (
    .ref_clk_i, .rst_b_i, .dtr_on_i, .rts_on_i, .loop_i, .baud_clk_i, .sout_i, .tx_busy_i,
    .extended_control_one_bit7_i, .cts_o, .dsr_o, .dcd_o, .ring_o, .rx_valid_o,
    .rx_data_o, .rx_ready_i, .cfg_base_o, .test_mode_o, .strap_done_o, .cts_b_i,
    .dsr_b_i, .dcd_b_i, .ri_b_i, .sout_o, .rts_b_o, .rts_b_oe_o, .port1_rts_pin_i,
    .port_terminal_ready_or_baud_pin_o, .port_terminal_ready_or_baud_pin_oe_o,
    .port1_terminal_ready_or_baud_pin_i
);
`default_nettype wire

// File: tb/spm_modem.sv
// far-side modem model: low-true status pins, data echo, strap pulls
`timescale 1ns/1ps
`default_nettype none
module spm_modem #(
    parameter int PORTS = 2,
    parameter int LAG   = 2
) (
    input  wire logic               ref_clk_i,
    input  wire logic [4*PORTS-1:0] cmd_i,       // ring, carrier, link, ready
    input  wire logic [PORTS-1:0]   sout_i,      // device serial out
    output logic      [4*PORTS-1:0] pins_b_o,    // ri, dcd, dsr, cts pins
    output logic      [PORTS-1:0]   sin_o,       // echoed serial data
    input  wire logic               addr_pull_i, // address strap pull level
    input  wire logic               test_pull_i, // test strap pull level
    input  wire logic               dtr_pin_i,
    input  wire logic               dtr_oe_i,
    input  wire logic               rts_pin_i,
    input  wire logic               rts_oe_i,
    output logic                    dtr_lvl_o,   // resolved port 1 dtr wire
    output logic                    rts_lvl_o    // resolved port 1 rts wire
);
    // answer pipeline, idle lines start high
    logic [5*PORTS-1:0] pipe_r [LAG] = '{default: '1};

    // far device answers LAG clocks after its command, asserting low
    always @(posedge ref_clk_i)
    begin
        pipe_r[0] <= {sout_i, ~cmd_i};
        for (int k = 1; k < LAG; k++)
            pipe_r[k] <= pipe_r[k-1];
    end
    assign {sin_o, pins_b_o} = pipe_r[LAG-1];

    // a released strap pin settles to its pull level
    assign dtr_lvl_o = dtr_oe_i ? dtr_pin_i : addr_pull_i;
    assign rts_lvl_o = rts_oe_i ? rts_pin_i : test_pull_i;
endmodule // spm_modem
`default_nettype wire

// File: tb/tb.sv
// self-checking bench for the serial port pin stage
`timescale 1ns/1ps
`default_nettype none
module tb;
    import spm_pkg::*;
    localparam int P = SPM_PORTS;

    // uart-side controls, fifo stream, far-side commands
    logic           ref_clk_i  = 1'b0;
    logic           rst_b_i    = 1'b0;
    logic [P-1:0]   dtr_on_i   = '0;
    logic [P-1:0]   rts_on_i   = '0;
    logic [P-1:0]   loop_i     = '0;
    logic [P-1:0]   baud_clk_i = '0;
    logic [P-1:0]   sout_i     = '0;
    logic [P-1:0]   tx_busy_i  = '0;
    logic [P-1:0]   extended_control_one_bit7_i = '0;
    logic           rx_valid_i = 1'b0;
    logic [7:0]     rx_data_i  = 8'h00;
    logic           rx_ready_i = 1'b0;
    logic [4*P-1:0] cmd        = '0;
    logic           addr_pull  = 1'b0;
    logic           test_pull  = 1'b0;
    // design outputs and modem-driven pins
    logic [P-1:0] cts_o, dsr_o, dcd_o, ring_o, sin_o, sout_o, rts_b_o, rts_b_oe_o;
    logic [P-1:0] port_terminal_ready_or_baud_pin_o, port_terminal_ready_or_baud_pin_oe_o;
    logic         ring_wake_o, rx_ready_o, rx_valid_o, test_mode_o, strap_done_o;
    logic [7:0]   rx_data_o, cfg_base_o;
    wire  logic [P-1:0] cts_b_i, dsr_b_i, dcd_b_i, ri_b_i, sin_i;
    wire  logic   port1_rts_pin_i, port1_terminal_ready_or_baud_pin_i;
    logic [31:0]  seed = 32'h06F9AFE0;
    int           n_errors = 0;
    int           compares = 0;

    // 25 MHz clock
    always #20 ref_clk_i = ~ref_clk_i;

    spm_pins dut (
        .ref_clk_i, .rst_b_i, .dtr_on_i, .rts_on_i, .loop_i, .baud_clk_i, .sout_i, .tx_busy_i,
        .extended_control_one_bit7_i, .cts_o, .dsr_o, .dcd_o, .ring_o, .sin_o, .ring_wake_o,
        .rx_valid_i, .rx_data_i, .rx_ready_o, .rx_valid_o, .rx_data_o, .rx_ready_i,
        .cfg_base_o, .test_mode_o, .strap_done_o, .cts_b_i, .dsr_b_i, .dcd_b_i, .ri_b_i,
        .sin_i, .sout_o, .rts_b_o, .rts_b_oe_o, .port1_rts_pin_i,
        .port_terminal_ready_or_baud_pin_o, .port_terminal_ready_or_baud_pin_oe_o,
        .port1_terminal_ready_or_baud_pin_i
    );

    spm_modem #(.PORTS(P), .LAG(2)) u_modem (
        .ref_clk_i, .cmd_i(cmd), .sout_i(sout_o), .pins_b_o({ri_b_i, dcd_b_i, dsr_b_i, cts_b_i}),
        .sin_o(sin_i), .addr_pull_i(addr_pull), .test_pull_i(test_pull),
        .dtr_pin_i(port_terminal_ready_or_baud_pin_o[0]),
        .dtr_oe_i(port_terminal_ready_or_baud_pin_oe_o[0]),
        .rts_pin_i(rts_b_o[0]), .rts_oe_i(rts_b_oe_o[0]),
        .rts_lvl_o(port1_rts_pin_i), .dtr_lvl_o(port1_terminal_ready_or_baud_pin_i)
    );

    // xorshift source
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // compare one value, count and report
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp)
        begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask

    // verdict and end of run
    task automatic tally_and_finish();
        if (n_errors == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // reset with given strap pulls, uart asking for active pins meanwhile
    task automatic do_reset(input logic ap, input logic tp);
        int k;
        @(negedge ref_clk_i);
        rst_b_i = 1'b0;
        addr_pull = ap;
        test_pull = tp;
        {dtr_on_i, rts_on_i, tx_busy_i} = '1;
        {sout_i, loop_i, extended_control_one_bit7_i} = '0;
        repeat (20) @(negedge ref_clk_i);
        chk("reset pins", 8'h3F, 8'({sout_o, rts_b_o, port_terminal_ready_or_baud_pin_o}));
        rst_b_i = 1'b1;
        k = 0;
        while (strap_done_o !== 1'b1 && k < 10)
        begin
            @(negedge ref_clk_i);
            k++;
        end
        chk("cfg base", ap ? 8'h4E : 8'h2E, cfg_base_o);
        chk("test mode", 8'(tp), 8'(test_mode_o));
    endtask

    // random controls and status, model compared every cycle
    task automatic run_mix(input int n);
        logic [31:0]  r;
        logic [5*P-1:0] hist[$];
        logic [5*P-1:0] h;
        logic [4*P-1:0] st;
        logic [P-1:0] e7, ed, er, es;
        for (int i = 0; i < n; i++)
        begin
            @(negedge ref_clk_i);
            e7 = extended_control_one_bit7_i;
            ed = (e7 & baud_clk_i) | (~e7 & (loop_i | ~dtr_on_i));
            er = loop_i | ~rts_on_i;
            es = ~(tx_busy_i & ~loop_i) | sout_i;
            chk("dtr pin", 8'(ed), 8'(port_terminal_ready_or_baud_pin_o));
            chk("rts pin", 8'(er), 8'(rts_b_o));
            chk("sout pin", 8'(es), 8'(sout_o));
            chk("pin drive", 8'h0F, 8'({rts_b_oe_o, port_terminal_ready_or_baud_pin_oe_o}));
            if (hist.size() >= 3)
            begin
                // pins three cycles back: status, serial in, wake
                h  = hist[$-2];
                st = {ring_o, dcd_o, dsr_o, cts_o};
                chk("status", 8'(~h), 8'(st));
                chk("serial in", 8'(h[5*P-1:4*P]), 8'(sin_o));
                chk("ring wake", 8'(|(~h[4*P-1:3*P])), 8'(ring_wake_o));
            end
            hist.push_back({sin_i, ri_b_i, dcd_b_i, dsr_b_i, cts_b_i});
            r = xs();
            {baud_clk_i, sout_i, tx_busy_i, loop_i, rts_on_i, dtr_on_i} = r[11:0];
            cmd = r[19:12];
            extended_control_one_bit7_i = r[21:20] & r[23:22];
        end
    endtask

    // fill the fifo until refused, then drain with stalls
    task automatic run_fifo();
        logic [31:0] r;
        logic [7:0]  q[$];
        for (int k = 0; k < 40; k++)
        begin
            @(negedge ref_clk_i);
            r = xs();
            rx_valid_i = 1'b1;
            rx_data_i = r[7:0];
            if (rx_ready_o === 1'b1)
                q.push_back(rx_data_i);
        end
        chk("fifo capacity", 8'd33, 8'(q.size()));
        @(negedge ref_clk_i);
        rx_valid_i = 1'b0;
        for (int k = 0; k < 300 && q.size() > 0; k++)
        begin
            @(negedge ref_clk_i);
            r = xs();
            rx_ready_i = r[0];
            if (rx_valid_o === 1'b1 && rx_ready_i)
                chk("fifo data", q.pop_front(), rx_data_o);
        end
        @(negedge ref_clk_i);
        chk("fifo left", 8'h00, 8'({q.size(), rx_valid_o}));
    endtask

    // main sequence: every strap combination, then the fifo
    initial
    begin
        for (int s = 0; s < 4; s++)
        begin
            do_reset(s[0], s[1]);
            run_mix(60);
        end
        run_fifo();
        tally_and_finish();
    end

    // watchdog well beyond the expected run
    initial
    begin
        repeat (5000) @(posedge ref_clk_i);
        n_errors++;
        tally_and_finish();
    end
endmodule // tb
`default_nettype wire
